// ---- verilog/asw_regs.svh ----
// Register map, field positions, reset values and timing figures of the switch register bank.
// Assumes inclusion by bare name from the design; holds definitions only.
`ifndef ASW_REGS_SVH
`define ASW_REGS_SVH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ASW_ADDR_ID        8'h01
`define ASW_ADDR_CTRL      8'h02
`define ASW_ADDR_ST1       8'h03
`define ASW_ADDR_ST2       8'h04
`define ASW_ADDR_MASK1     8'h05
`define ASW_ADDR_MASK2     8'h06
`define ASW_ADDR_ADC       8'h07
`define ASW_ADDR_TIM1      8'h08
`define ASW_ADDR_TIM2      8'h09
`define ASW_ADDR_ACC1      8'h0A
`define ASW_ADDR_ACC2      8'h0B
`define ASW_ADDR_KEY1      8'h0C
`define ASW_ADDR_KEY2      8'h0D
`define ASW_ADDR_HOLE      8'h0E
`define ASW_ADDR_SP1       8'h0F
`define ASW_ADDR_SP2       8'h10
`define ASW_ADDR_SPM1      8'h11
`define ASW_ADDR_SPM2      8'h12
`define ASW_ADDR_ROUTE1    8'h13
`define ASW_ADDR_ROUTE2    8'h14
`define ASW_ADDR_FIRST     8'h01
`define ASW_ADDR_LAST      8'h14
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define ASW_CTRL_INT_MASK  0
`define ASW_CTRL_WAIT      1
`define ASW_CTRL_AUTO      2
`define ASW_CTRL_RAW_OFF   3
`define ASW_CTRL_CLOSE_OK  4
`define ASW_CTRL_RST       5'h1F
`define ASW_ADC_RST        5'h1F
`define ASW_ST2_ADC_CHG    2
`define ASW_ST2_CONNECT    5
`define ASW_TIM_WAIT_MSB   7
`define ASW_TIM_WAIT_LSB   4
// ----------------------------------------
// Timing
// ----------------------------------------
`define ASW_CLK_PERIOD_NS  50
`define ASW_NS_PER_MS      1000000
`define ASW_WAIT_BASE_MS   10
`define ASW_WAIT_STEP_MS   20
`define ASW_WAIT_MAX_CODE  4'hA
`endif

// ---- verilog/asw_pkg.sv ----
// Types shared by the switch register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package asw_pkg;
    // ----------------------------------------
    // Switching sequence
    // ----------------------------------------
    typedef enum logic [1:0] {
        SW_IDLE,
        SW_WAIT,
        SW_GO
    } asw_sw_state_t;
endpackage : asw_pkg

// ---- verilog/asw_register_bank.sv ----
// Host-visible register bank of the accessory connector switch.
// Assumes a serial bus engine in front that hands over command bytes, data bytes and master acks.
`timescale 1ns/1ps
`include "asw_regs.svh"

module asw_register_bank #(
    parameter int unsigned MS_TICK_CYCLES = `ASW_NS_PER_MS / `ASW_CLK_PERIOD_NS,
    parameter logic [2:0]  SUPPLIER_CODE  = 3'h5,  // Arbitrary value
    parameter logic [4:0]  REVISION_CODE  = 5'h0C  // Arbitrary value
) (
    // Clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       rst_n_in,
    // Byte handover from the serial engine
    input  wire logic       sub_addr_load_in,
    input  wire logic [7:0] sub_addr_in,
    input  wire logic       data_wr_in,
    input  wire logic [7:0] data_wr_byte_in,
    input  wire logic       data_rd_in,
    input  wire logic       master_ack_in,
    output logic      [7:0] rd_byte_out,
    // Detector events, one-cycle pulses
    input  wire logic [7:0] evt_first_in,
    input  wire logic [6:0] evt_second_in,
    input  wire logic [7:0] spare_evt_first_in,
    input  wire logic [3:0] spare_evt_second_in,
    // Detector levels
    input  wire logic [4:0] adc_code_in,
    input  wire logic [7:0] accessory_first_in,
    input  wire logic [7:0] accessory_second_in,
    input  wire logic [7:0] key_first_in,
    input  wire logic [6:0] key_second_in,
    input  wire logic       sw_request_in,
    input  wire logic [7:0] auto_route_first_in,
    input  wire logic [4:0] auto_route_second_in,
    // Switch and host side
    output logic            irq_n_out,
    output logic      [7:0] route_first_out,
    output logic      [4:0] route_second_out,
    output logic            load_switch_on_out,
    output logic      [7:0] timing_first_out,
    output logic      [7:0] timing_second_out
);
    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    generate
        if (MS_TICK_CYCLES < 1 || MS_TICK_CYCLES > 65535) begin : g_bad_tick
            $error("MS_TICK_CYCLES must lie in 1..65535");
        end
    endgenerate

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [4:0] ctrl_q;
    logic [7:0] st1_q;
    logic [6:0] st2_q;
    logic [7:0] mask1_q;
    logic [6:0] mask2_q;
    logic [4:0] adc_q;
    logic [7:0] sp1_q;
    logic [3:0] sp2_q;
    logic [7:0] spm1_q;
    logic [3:0] spm2_q;
    logic [7:0] route1_q;
    logic [4:0] route2_q;
    logic [7:0] ptr_q;
    logic [7:0] rd_addr_q;
    logic       rd_valid_q;
    logic [7:0] auto1_q;
    logic [4:0] auto2_q;
    logic [15:0] tick_q;
    logic [7:0] ms_q;
    asw_pkg::asw_sw_state_t sw_state_q;

    logic [7:0] rd_mux;
    logic       ack_take;
    logic       host_go;
    logic       adc_chg;
    logic [7:0] wait_ms;
    logic       pending;

    function automatic logic [7:0] next_addr(input logic [7:0] a);
        if (a >= `ASW_ADDR_LAST || a < `ASW_ADDR_FIRST) begin
            return `ASW_ADDR_FIRST;
        end
        return a + 8'h01;
    endfunction : next_addr

    function automatic logic [7:0] clear_bits(input logic [7:0] target);
        return (ack_take && rd_addr_q == target) ? rd_byte_out : 8'h00;
    endfunction : clear_bits

    // ----------------------------------------
    // Address pointer and read path
    // ----------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ptr_q <= `ASW_ADDR_FIRST;
        end else if (sub_addr_load_in) begin
            ptr_q <= sub_addr_in;
        end else if (data_wr_in || data_rd_in) begin
            ptr_q <= next_addr(ptr_q);
        end
    end

    always_comb begin
        case (ptr_q)
            `ASW_ADDR_ID:     rd_mux = {REVISION_CODE, SUPPLIER_CODE};
            `ASW_ADDR_CTRL:   rd_mux = {3'h0, ctrl_q};
            `ASW_ADDR_ST1:    rd_mux = st1_q;
            `ASW_ADDR_ST2:    rd_mux = {1'b0, st2_q};
            `ASW_ADDR_MASK1:  rd_mux = mask1_q;
            `ASW_ADDR_MASK2:  rd_mux = {1'b0, mask2_q};
            `ASW_ADDR_ADC:    rd_mux = {3'h0, adc_q};
            `ASW_ADDR_TIM1:   rd_mux = timing_first_out;
            `ASW_ADDR_TIM2:   rd_mux = timing_second_out;
            `ASW_ADDR_ACC1:   rd_mux = accessory_first_in;
            `ASW_ADDR_ACC2:   rd_mux = accessory_second_in;
            `ASW_ADDR_KEY1:   rd_mux = key_first_in;
            `ASW_ADDR_KEY2:   rd_mux = {1'b0, key_second_in};
            `ASW_ADDR_SP1:    rd_mux = sp1_q;
            `ASW_ADDR_SP2:    rd_mux = {4'h0, sp2_q};
            `ASW_ADDR_SPM1:   rd_mux = spm1_q;
            `ASW_ADDR_SPM2:   rd_mux = {4'h0, spm2_q};
            `ASW_ADDR_ROUTE1: rd_mux = route1_q;
            `ASW_ADDR_ROUTE2: rd_mux = {3'h0, route2_q};
            default:          rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_byte_out <= 8'h00;
            rd_addr_q   <= 8'h00;
            rd_valid_q  <= 1'b0;
        end else if (data_rd_in) begin
            rd_byte_out <= rd_mux;
            rd_addr_q   <= ptr_q;
            rd_valid_q  <= 1'b1;
        end else if (master_ack_in || sub_addr_load_in) begin
            rd_valid_q  <= 1'b0;
        end
    end

    // Only the bits actually shipped are cleared, so an event landing between load and ack survives
    assign ack_take = master_ack_in && rd_valid_q && !data_rd_in;

    // ----------------------------------------
    // Host-written registers
    // ----------------------------------------
    assign host_go = data_wr_in && ptr_q == `ASW_ADDR_CTRL && !ctrl_q[`ASW_CTRL_WAIT]
                     && data_wr_byte_in[`ASW_CTRL_WAIT];

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q            <= `ASW_CTRL_RST;
            mask1_q           <= 8'h00;
            mask2_q           <= 7'h00;
            spm1_q            <= 8'h00;
            spm2_q            <= 4'h0;
            route1_q          <= 8'h00;
            route2_q          <= 5'h00;
            timing_first_out  <= 8'h00;
            timing_second_out <= 8'h00;
        end else if (data_wr_in) begin
            // Read-only and unmapped targets fall through unchanged
            case (ptr_q)
                `ASW_ADDR_CTRL:   ctrl_q            <= data_wr_byte_in[4:0];
                `ASW_ADDR_MASK1:  mask1_q           <= data_wr_byte_in;
                `ASW_ADDR_MASK2:  mask2_q           <= data_wr_byte_in[6:0];
                `ASW_ADDR_SPM1:   spm1_q            <= data_wr_byte_in;
                `ASW_ADDR_SPM2:   spm2_q            <= data_wr_byte_in[3:0];
                `ASW_ADDR_ROUTE1: route1_q          <= data_wr_byte_in;
                `ASW_ADDR_ROUTE2: route2_q          <= data_wr_byte_in[4:0];
                `ASW_ADDR_TIM1:   timing_first_out  <= data_wr_byte_in;
                `ASW_ADDR_TIM2:   timing_second_out <= data_wr_byte_in;
                default:          ;
            endcase
        end
    end

    // ----------------------------------------
    // Event status, set wins over clear
    // ----------------------------------------
    assign adc_chg = adc_code_in != adc_q && !ctrl_q[`ASW_CTRL_RAW_OFF];

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            adc_q <= `ASW_ADC_RST;
        end else begin
            adc_q <= adc_code_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st1_q <= 8'h00;
            st2_q <= 7'h00;
        end else begin
            st1_q <= (st1_q & ~clear_bits(`ASW_ADDR_ST1)) | evt_first_in;
            st2_q <= (st2_q & ~7'(clear_bits(`ASW_ADDR_ST2)))
                     | {evt_second_in[6],
                        evt_second_in[5] || sw_state_q == asw_pkg::SW_GO,
                        evt_second_in[4:3],
                        adc_chg,
                        evt_second_in[1:0]};
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sp1_q <= 8'h00;
            sp2_q <= 4'h0;
        end else begin
            sp1_q <= (sp1_q & ~clear_bits(`ASW_ADDR_SP1)) | spare_evt_first_in;
            sp2_q <= (sp2_q & ~4'(clear_bits(`ASW_ADDR_SP2))) | spare_evt_second_in;
        end
    end

    // ----------------------------------------
    // Interrupt output
    // ----------------------------------------
    assign pending = |(st1_q & ~mask1_q) || |(st2_q & ~mask2_q)
                     || |(sp1_q & ~spm1_q) || |(sp2_q & ~spm2_q);

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            irq_n_out <= 1'b1;
        end else begin
            irq_n_out <= !(pending && !ctrl_q[`ASW_CTRL_INT_MASK]);
        end
    end

    // ----------------------------------------
    // Switching wait timer
    // ----------------------------------------
    // Codes above the table saturate at the longest wait rather than wrapping
    always_comb begin
        logic [3:0] code;
        code = timing_second_out[`ASW_TIM_WAIT_MSB:`ASW_TIM_WAIT_LSB];
        if (code > `ASW_WAIT_MAX_CODE) begin
            code = `ASW_WAIT_MAX_CODE;
        end
        wait_ms = 8'(`ASW_WAIT_BASE_MS) + 8'(`ASW_WAIT_STEP_MS) * {4'h0, code};
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_q <= 16'h0000;
            ms_q   <= 8'h00;
        end else if (sw_state_q != asw_pkg::SW_WAIT) begin
            tick_q <= 16'h0000;
            ms_q   <= 8'h00;
        end else if (tick_q == 16'(MS_TICK_CYCLES - 1)) begin
            tick_q <= 16'h0000;
            ms_q   <= (ms_q == 8'hFF) ? ms_q : ms_q + 8'h01;
        end else begin
            tick_q <= tick_q + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sw_state_q <= asw_pkg::SW_IDLE;
        end else begin
            case (sw_state_q)
                asw_pkg::SW_IDLE: begin
                    if (sw_request_in) begin
                        sw_state_q <= asw_pkg::SW_WAIT;
                    end
                end
                asw_pkg::SW_WAIT: begin
                    if (host_go || (ctrl_q[`ASW_CTRL_WAIT] && ms_q >= wait_ms)) begin
                        sw_state_q <= asw_pkg::SW_GO;
                    end
                end
                default: begin
                    sw_state_q <= asw_pkg::SW_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Switch paths
    // ----------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            auto1_q <= 8'h00;
            auto2_q <= 5'h00;
        end else if (sw_state_q == asw_pkg::SW_GO) begin
            auto1_q <= auto_route_first_in;
            auto2_q <= auto_route_second_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            route_first_out    <= 8'h00;
            route_second_out   <= 5'h00;
            load_switch_on_out <= 1'b0;
        end else if (!ctrl_q[`ASW_CTRL_CLOSE_OK]) begin
            route_first_out    <= 8'h00;
            route_second_out   <= 5'h00;
            load_switch_on_out <= 1'b0;
        end else if (!ctrl_q[`ASW_CTRL_AUTO]) begin
            route_first_out    <= route1_q;
            route_second_out   <= route2_q;
            load_switch_on_out <= 1'b1;
        end else begin
            route_first_out    <= auto1_q;
            route_second_out   <= auto2_q;
            load_switch_on_out <= 1'b1;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence sw_req_s;
        sw_state_q == asw_pkg::SW_IDLE && sw_request_in;
    endsequence

    sequence held_s;
        sw_state_q == asw_pkg::SW_WAIT && !ctrl_q[`ASW_CTRL_WAIT] && !host_go;
    endsequence

    global_mask_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        ctrl_q[`ASW_CTRL_INT_MASK] |=> irq_n_out) else $error("irq while globally masked");
    hold_wait_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        sw_req_s ##1 held_s |=> sw_state_q == asw_pkg::SW_WAIT) else $error("switched without host");
    manual_route_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        ctrl_q[`ASW_CTRL_CLOSE_OK] && !ctrl_q[`ASW_CTRL_AUTO] |=> route_first_out == $past(route1_q))
        else $error("manual route not applied");
    raw_quiet_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(st2_q[`ASW_ST2_ADC_CHG]) |-> !$past(ctrl_q[`ASW_CTRL_RAW_OFF])) else $error("raw change reported");
    open_all_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        !ctrl_q[`ASW_CTRL_CLOSE_OK] |=> !load_switch_on_out && route_first_out == 8'h00)
        else $error("switch closed while open");
    ack_clear_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        ack_take && rd_addr_q == `ASW_ADDR_ST1 && evt_first_in == 8'h00
        |=> st1_q == ($past(st1_q) & ~$past(rd_byte_out))) else $error("status not cleared on ack");
    attach_set_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        evt_first_in[0] |=> st1_q[0]) else $error("attach lost");
    key_set_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        evt_first_in[2] |=> st1_q[2]) else $error("key press lost");
    addr_wrap_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        data_wr_in && !sub_addr_load_in && ptr_q == `ASW_ADDR_LAST |=> ptr_q == `ASW_ADDR_FIRST)
        else $error("burst did not wrap");
    irq_release_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        !pending |=> irq_n_out) else $error("irq held without cause");
    unmapped_zero_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        data_rd_in && ptr_q == `ASW_ADDR_HOLE |=> rd_byte_out == 8'h00) else $error("unmapped read nonzero");
    connect_set_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
        sw_state_q == asw_pkg::SW_GO |=> st2_q[`ASW_ST2_CONNECT]) else $error("connect not flagged");

endmodule : asw_register_bank

// ---- verif/asw_host_model.sv ----
// Host side model: the serial engine handing command, data and ack to the bank.
// Assumes the bank samples its register port on the rising edge of ref_clk_in.
`timescale 1ns/1ps
module asw_host_model (
    // Clock
    input  wire logic       ref_clk_in,
    // Register port
    output logic            sub_addr_load_out,
    output logic      [7:0] sub_addr_out,
    output logic            data_wr_out,
    output logic      [7:0] data_wr_byte_out,
    output logic            data_rd_out,
    output logic            master_ack_out,
    input  wire logic [7:0] rd_byte_in
);
    initial begin
        sub_addr_load_out = 1'b0;
        sub_addr_out      = 8'h00;
        data_wr_out       = 1'b0;
        data_wr_byte_out  = 8'h00;
        data_rd_out       = 1'b0;
        master_ack_out    = 1'b0;
    end
    // Released lanes show the inverse, so a stale byte never looks valid
    task automatic set_ptr(input logic [7:0] addr);
        @(posedge ref_clk_in);
        sub_addr_load_out <= 1'b1;
        sub_addr_out      <= addr;
        @(posedge ref_clk_in);
        sub_addr_load_out <= 1'b0;
        sub_addr_out      <= ~addr;
    endtask : set_ptr
    task automatic wr_next(input logic [7:0] data);
        @(posedge ref_clk_in);
        data_wr_out      <= 1'b1;
        data_wr_byte_out <= data;
        @(posedge ref_clk_in);
        data_wr_out      <= 1'b0;
        data_wr_byte_out <= ~data;
    endtask : wr_next
    task automatic rd_next(input logic ack, output logic [7:0] data);
        @(posedge ref_clk_in);
        data_rd_out <= 1'b1;
        @(posedge ref_clk_in);
        data_rd_out    <= 1'b0;
        master_ack_out <= ack;
        @(negedge ref_clk_in);
        data = rd_byte_in;
        @(posedge ref_clk_in);
        master_ack_out <= 1'b0;
    endtask : rd_next
    // Start-up blocking of unused interrupts
    task automatic spare_setup;
        set_ptr(8'h11);
        wr_next(8'hFF);
        wr_next(8'h0F);
    endtask : spare_setup
    // Leftover spare events are cleared by reading both spare status registers
    task automatic spare_sweep;
        logic [7:0] dummy;
        set_ptr(8'h0F);
        rd_next(1'b1, dummy);
        rd_next(1'b1, dummy);
    endtask : spare_sweep
endmodule : asw_host_model

// ---- verif/testbench.sv ----
// Self-checking bench for the accessory switch register bank.
// Assumes the bank and the host model are compiled first; one 20 MHz clock.
`timescale 1ns/1ps
module testbench;
    localparam int         TICK   = 4;
    localparam logic [2:0] SUP_ID = 3'h6;  // Arbitrary value
    localparam logic [4:0] REV_ID = 5'h11; // Arbitrary value
    logic        ref_clk_in = 1'b0;
    logic        rst_n_in   = 1'b0;
    logic        addr_load, data_wr, data_rd, master_ack, irq_n, load_on;
    logic [7:0]  sub_addr, wr_byte, rd_byte, route_first, timing_first;
    logic [7:0]  evt_first = 8'h00, spare_first = 8'h00, auto_first = 8'h00;
    logic [6:0]  evt_second = 7'h00;
    logic [4:0]  adc_code = 5'h1F, auto_second = 5'h00, route_second;
    logic        sw_request = 1'b0;
    logic [7:0]  acc_first = 8'h4B, acc_second = 8'hC3, key_first = 8'h81, timing_second;
    logic [6:0]  key_second = 7'h35;
    logic [3:0]  spare_second = 4'h0;
    int          n_fail = 0, tests_run = 0;
    logic [15:0] reset_rows [0:12] = '{16'h018E, 16'h021F, 16'h0300, 16'h0500, 16'h071F, 16'h0800, 16'h0900,
                                       16'h0A4B, 16'h0BC3, 16'h0C81, 16'h0D35, 16'h1100, 16'h0E00};
    initial forever #25 ref_clk_in = ~ref_clk_in;
    asw_host_model host (
        .ref_clk_in(ref_clk_in), .sub_addr_load_out(addr_load), .sub_addr_out(sub_addr),
        .data_wr_out(data_wr), .data_wr_byte_out(wr_byte), .data_rd_out(data_rd),
        .master_ack_out(master_ack), .rd_byte_in(rd_byte));
    asw_register_bank #(.MS_TICK_CYCLES(TICK), .SUPPLIER_CODE(SUP_ID), .REVISION_CODE(REV_ID)) uut (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sub_addr_load_in(addr_load), .sub_addr_in(sub_addr),
        .data_wr_in(data_wr), .data_wr_byte_in(wr_byte), .data_rd_in(data_rd), .master_ack_in(master_ack),
        .rd_byte_out(rd_byte), .evt_first_in(evt_first), .evt_second_in(evt_second),
        .spare_evt_first_in(spare_first), .spare_evt_second_in(spare_second), .adc_code_in(adc_code),
        .accessory_first_in(acc_first), .accessory_second_in(acc_second), .key_first_in(key_first),
        .key_second_in(key_second),
        .sw_request_in(sw_request), .auto_route_first_in(auto_first), .auto_route_second_in(auto_second),
        .irq_n_out(irq_n), .route_first_out(route_first), .route_second_out(route_second),
        .load_switch_on_out(load_on), .timing_first_out(timing_first), .timing_second_out(timing_second));
    task automatic tally_and_finish;
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] addr, input logic ack, input logic [7:0] exp);
        logic [7:0] data;
        host.set_ptr(addr);
        host.rd_next(ack, data);
        chk(data, exp);
    endtask : rd
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        host.set_ptr(addr);
        host.wr_next(data);
    endtask : wr
    task automatic fire(input logic [7:0] e1, input logic [6:0] e2, input logic [7:0] s1);
        @(posedge ref_clk_in);
        evt_first   <= e1;
        evt_second  <= e2;
        spare_first <= s1;
        @(posedge ref_clk_in);
        evt_first   <= 8'h00;
        evt_second  <= 7'h00;
        spare_first <= 8'h00;
    endtask : fire
    task automatic irq_after(input logic lvl);
        repeat (3) @(negedge ref_clk_in);
        chk({7'h00, irq_n}, {7'h00, lvl});
    endtask : irq_after
    task automatic sw_go(input logic [7:0] route);
        @(posedge ref_clk_in);
        auto_first <= route;
        sw_request <= 1'b1;
        @(posedge ref_clk_in);
        sw_request <= 1'b0;
    endtask : sw_go
    // Bounded wait: running out counts a mismatch and ends the run
    task automatic wait_route(input logic [7:0] exp, input int limit);
        for (int i = 0; i < limit && route_first !== exp; i++) @(negedge ref_clk_in);
        chk(route_first, exp);
        if (route_first !== exp) tally_and_finish();
    endtask : wait_route
    initial begin
        repeat (3) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        for (int i = 0; i < 13; i++) rd(reset_rows[i][15:8], 1'b1, reset_rows[i][7:0]);
        irq_after(1'b1);
        wr(8'h01, 8'h00);
        rd(8'h01, 1'b0, {REV_ID, SUP_ID});
        wr(8'h0E, 8'hAA);
        rd(8'h0E, 1'b0, 8'h00);
        wr(8'h08, 8'h37);
        @(negedge ref_clk_in);
        chk(timing_first, 8'h37);
        wr(8'h09, 8'h05);
        @(negedge ref_clk_in);
        chk(timing_second, 8'h05);
        // Burst past the last register wraps to the first; identity write is dropped
        host.set_ptr(8'h13);
        host.wr_next(8'h1A);
        host.wr_next(8'h05);
        host.wr_next(8'h00);
        host.wr_next(8'h12);
        rd(8'h02, 1'b0, 8'h12);
        rd(8'h01, 1'b0, {REV_ID, SUP_ID});
        chk(route_first, 8'h1A);
        chk({3'h0, route_second}, 8'h05);
        chk({7'h00, load_on}, 8'h01);
        for (int i = 0; i < 8; i++) begin
            fire(8'h01 << i, 7'h00, 8'h00);
            irq_after(1'b0);
            rd(8'h03, 1'b1, 8'h01 << i);
            irq_after(1'b1);
        end
        for (int i = 0; i < 7; i++) begin
            if (i != 2) begin
                fire(8'h00, 7'h01 << i, 8'h00);
                rd(8'h04, 1'b1, 8'h01 << i);
                irq_after(1'b1);
            end
        end
        fire(8'h01, 7'h00, 8'h00);
        rd(8'h03, 1'b0, 8'h01);
        rd(8'h03, 1'b1, 8'h01);
        rd(8'h03, 1'b1, 8'h00);
        wr(8'h05, 8'h01);
        fire(8'h01, 7'h00, 8'h00);
        irq_after(1'b1);
        rd(8'h03, 1'b1, 8'h01);
        wr(8'h05, 8'h00);
        wr(8'h02, 8'h13);
        fire(8'h02, 7'h00, 8'h00);
        irq_after(1'b1);
        wr(8'h02, 8'h12);
        irq_after(1'b0);
        rd(8'h03, 1'b1, 8'h02);
        @(posedge ref_clk_in);
        adc_code <= 5'h05;
        rd(8'h04, 1'b1, 8'h04);
        wr(8'h02, 8'h1A);
        @(posedge ref_clk_in);
        adc_code <= 5'h09;
        rd(8'h04, 1'b1, 8'h00);
        rd(8'h07, 1'b1, 8'h09);
        wr(8'h02, 8'h12);
        fire(8'h00, 7'h00, 8'h80);
        irq_after(1'b0);
        rd(8'h03, 1'b1, 8'h00);
        rd(8'h04, 1'b1, 8'h00);
        host.spare_sweep();
        irq_after(1'b1);
        host.spare_setup();
        fire(8'h00, 7'h00, 8'h81);
        irq_after(1'b1);
        rd(8'h0F, 1'b1, 8'h81);
        rd(8'h12, 1'b0, 8'h0F);
        @(posedge ref_clk_in);
        spare_second <= 4'h9;
        @(posedge ref_clk_in);
        spare_second <= 4'h0;
        rd(8'h10, 1'b1, 8'h09);
        wr(8'h02, 8'h16);
        auto_second <= 5'h11;
        sw_go(8'h3C);
        repeat (30) @(negedge ref_clk_in);
        chk(route_first, 8'h00);
        wait_route(8'h3C, 30);
        chk({3'h0, route_second}, 8'h11);
        rd(8'h04, 1'b1, 8'h20);
        wr(8'h02, 8'h14);
        sw_go(8'h5A);
        repeat (60) @(negedge ref_clk_in);
        chk(route_first, 8'h3C);
        wr(8'h02, 8'h16);
        wait_route(8'h5A, 20);
        rd(8'h04, 1'b1, 8'h20);
        wr(8'h02, 8'h06);
        repeat (3) @(negedge ref_clk_in);
        chk(route_first, 8'h00);
        chk({7'h00, load_on}, 8'h00);
        tally_and_finish();
    end
endmodule : testbench
